// File: hdl/cgn_bit_timer.v
// Bit-time generator for the bus side.
// Assumes div is at least 4 and stays steady while the bus is in use.
`timescale 1ns/1ps
module cgn_bit_timer #(
	parameter DW = 16
) (
	// Clock and reset
	input wire clk,
	input wire reset_n,
	// Cycles per bit and resynchronisation
	input wire [DW-1:0] div,
	input wire restart,
	// Sample point and end of bit, one-cycle pulses
	output wire sample,
	output wire bit_end
);
	reg [DW-1:0] cnt_q;

	assign sample = (cnt_q == (div >> 1));
	assign bit_end = (cnt_q == div - {{(DW-1){1'b0}}, 1'b1});

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cnt_q <= {DW{1'b0}};
		end else if (restart || bit_end) begin
			cnt_q <= {DW{1'b0}};
		end else begin
			cnt_q <= cnt_q + {{(DW-1){1'b0}}, 1'b1};
		end
	end
endmodule

// File: hdl/cgn_consts.vh
// Constants of the gateway node-setup and bus-access block.
// Included by the node-setup design file and the bench; holds definitions only.
`ifndef CGN_CONSTS_VH
`define CGN_CONSTS_VH

// Register indices on the plain register port
`define CGN_REG_CTRL 4'h0
`define CGN_REG_NODE 4'h1
`define CGN_REG_RATE 4'h2
`define CGN_REG_DLO 4'h3
`define CGN_REG_DHI 4'h4
`define CGN_REG_STAT 4'h5
`define CGN_REG_PIDX 4'h6
`define CGN_REG_PDAT 4'h7

// Control register fields
`define CGN_CTRL_GO 0
`define CGN_CTRL_SDO 1
`define CGN_CTRL_DLC_LSB 8
`define CGN_CTRL_DLC_MSB 11

// Station address limits
`define CGN_DIGIT_MAX 4'h9
`define CGN_TENS_WEIGHT 7'h0A
`define CGN_MAX_ADDR 7'h63
`define CGN_PROTO_MAX_ADDR 7'h7F

// Bit-rate selector codes and rates in kbaud
`define CGN_RATE_AUTO 4'h0
`define CGN_RATE_MAX 4'h9
`define CGN_KBD_1 32'h0000000A
`define CGN_KBD_2 32'h00000014
`define CGN_KBD_3 32'h00000032
`define CGN_KBD_4 32'h00000064
`define CGN_KBD_5 32'h0000007D
`define CGN_KBD_6 32'h000000FA
`define CGN_KBD_7 32'h000001F4
`define CGN_KBD_8 32'h00000320
`define CGN_KBD_9 32'h000003E8
`define CGN_KBD_SCALE 32'h000003E8

// Identifier function codes: process data below service data
`define CGN_FC_PDO 4'h3
`define CGN_FC_SDO 4'hB

// Frame layout counts
`define CGN_IDLE_BITS 4'hB
`define CGN_ARB_BITS 7'h0D
`define CGN_HDR_BITS 7'h13
`define CGN_MAX_DLC 4'h8

// Autobaud: edges per measurement and tolerance shift
`define CGN_AUTO_EDGES 5'h10
`define CGN_TOL_SHIFT 3

// Startup settle time
`define CGN_STARTUP_NS 1000
`define CGN_CLK_PERIOD_NS 4

`endif

// File: hdl/cgn_node_setup.v
// Node setup and bus access of a serial-to-fieldbus gateway.
// Assumes selector and bus receive pins are asynchronous; register port is on clk.
`timescale 1ns/1ps
`include "cgn_consts.vh"
module cgn_node_setup #(
	parameter CLK_HZ = 250000000,
	parameter PARAM_DEPTH = 16,
	parameter PIDX_W = 4
) (
	// Clock and reset
	input wire clk,
	input wire reset_n,
	// Rotary selectors
	input wire [3:0] address_ones_selector,
	input wire [3:0] address_tens_selector,
	input wire [3:0] bit_rate_selector,
	input wire [3:0] attached_device_selector,
	// Bus transceiver
	input wire can_rx,
	output reg can_tx,
	// Register port
	input wire [3:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	// Status pins
	output reg power_ready_indicator,
	output reg [3:0] device_type,
	output reg comm_enable
);
	localparam STARTUP_CYC = (`CGN_STARTUP_NS + `CGN_CLK_PERIOD_NS - 1) / `CGN_CLK_PERIOD_NS;
	localparam [15:0] STARTUP_LAST = STARTUP_CYC - 1;
	localparam FRAME_W = 83;
	localparam ST_IDLE = 1'b0;
	localparam ST_SEND = 1'b1;

	// Cycles per bit for a rate code
	function [15:0] rate_div;
		input [3:0] code;
		integer t;
		begin
			case (code)
				4'h1: t = CLK_HZ / (`CGN_KBD_1 * `CGN_KBD_SCALE);
				4'h2: t = CLK_HZ / (`CGN_KBD_2 * `CGN_KBD_SCALE);
				4'h3: t = CLK_HZ / (`CGN_KBD_3 * `CGN_KBD_SCALE);
				4'h4: t = CLK_HZ / (`CGN_KBD_4 * `CGN_KBD_SCALE);
				4'h5: t = CLK_HZ / (`CGN_KBD_5 * `CGN_KBD_SCALE);
				4'h6: t = CLK_HZ / (`CGN_KBD_6 * `CGN_KBD_SCALE);
				4'h7: t = CLK_HZ / (`CGN_KBD_7 * `CGN_KBD_SCALE);
				4'h8: t = CLK_HZ / (`CGN_KBD_8 * `CGN_KBD_SCALE);
				4'h9: t = CLK_HZ / (`CGN_KBD_9 * `CGN_KBD_SCALE);
				default: t = CLK_HZ / (`CGN_KBD_9 * `CGN_KBD_SCALE);
			endcase
			rate_div = t[15:0];
		end
	endfunction

	wire [16:0] sync_out;
	wire [3:0] ones_s = sync_out[3:0];
	wire [3:0] tens_s = sync_out[7:4];
	wire [3:0] rate_s = sync_out[11:8];
	wire [3:0] dev_s = sync_out[15:12];
	wire rx_s = sync_out[16];

	cgn_sync3 #(
		.W(17),
		.RST(17'h10000)
	) u_sync (
		.clk(clk),
		.reset_n(reset_n),
		.async_in({can_rx, attached_device_selector, bit_rate_selector,
			address_tens_selector, address_ones_selector}),
		.sync_q(sync_out)
	);

	// Startup: let the selectors settle, then latch them once
	reg [15:0] start_cnt_q;
	reg [6:0] node_q;
	reg addr_ok_q;
	reg [3:0] rate_sel_q;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			start_cnt_q <= 16'h0000;
			power_ready_indicator <= 1'b0;
			node_q <= 7'h00;
			addr_ok_q <= 1'b0;
			rate_sel_q <= 4'h0;
			device_type <= 4'h0;
		end else if (!power_ready_indicator) begin
			start_cnt_q <= start_cnt_q + 16'h0001;
			if (start_cnt_q == STARTUP_LAST) begin
				power_ready_indicator <= 1'b1;
				node_q <= tens_s * `CGN_TENS_WEIGHT + {3'h0, ones_s};
				addr_ok_q <= (tens_s <= `CGN_DIGIT_MAX) && (ones_s <= `CGN_DIGIT_MAX);
				rate_sel_q <= rate_s;
				device_type <= dev_s;
			end
		end
	end

	// Autobaud: shortest edge spacing over a burst of edges
	reg rx_prev_q;
	reg [15:0] gap_q;
	reg [15:0] min_q;
	reg [4:0] edges_q;
	reg [3:0] det_code_q;
	reg auto_done_q;
	reg [3:0] match_code;
	reg [15:0] dv;
	reg [15:0] diff;
	integer i;
	wire rx_edge = rx_s ^ rx_prev_q;
	wire auto_mode = (rate_sel_q == `CGN_RATE_AUTO);

	always @* begin
		match_code = 4'h0;
		dv = 16'h0000;
		diff = 16'h0000;
		for (i = 1; i <= 9; i = i + 1) begin
			dv = rate_div(i[3:0]);
			diff = (min_q > dv) ? (min_q - dv) : (dv - min_q);
			if (diff <= (dv >> `CGN_TOL_SHIFT)) begin
				match_code = i[3:0];
			end
		end
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_prev_q <= 1'b1;
			gap_q <= 16'h0000;
			min_q <= 16'hFFFF;
			edges_q <= 5'h00;
			det_code_q <= 4'h0;
			auto_done_q <= 1'b0;
		end else begin
			rx_prev_q <= rx_s;
			if (rx_edge) begin
				gap_q <= 16'h0000;
			end else if (gap_q != 16'hFFFF) begin
				gap_q <= gap_q + 16'h0001;
			end
			if (power_ready_indicator && auto_mode && !auto_done_q && rx_edge) begin
				if (edges_q != 5'h00 && gap_q < min_q) begin
					min_q <= gap_q;
				end
				edges_q <= edges_q + 5'h01;
				if (edges_q == `CGN_AUTO_EDGES) begin
					edges_q <= 5'h00;
					min_q <= 16'hFFFF;
					if (match_code != 4'h0) begin
						det_code_q <= match_code;
						auto_done_q <= 1'b1;
					end
				end
			end
		end
	end

	// Effective rate and the gate for all bus traffic
	reg [6:0] cfg_node_q;
	reg [3:0] cfg_rate_q;
	reg cfg_node_set_q;
	reg cfg_rate_set_q;
	wire [3:0] eff_code = auto_mode ? det_code_q : rate_sel_q;
	wire rate_ok = (rate_sel_q <= `CGN_RATE_MAX) && (!auto_mode || auto_done_q);
	wire comm_d = power_ready_indicator && addr_ok_q && rate_ok
		&& cfg_node_set_q && (cfg_node_q == node_q)
		&& cfg_rate_set_q && (cfg_rate_q == eff_code);

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			comm_enable <= 1'b0;
		end else begin
			comm_enable <= comm_d;
		end
	end

	// Bit timing
	reg state_q;
	wire sample;
	wire bit_end;
	wire tx_start;
	wire hard_sync = (state_q == ST_IDLE) && rx_prev_q && !rx_s;

	cgn_bit_timer #(
		.DW(16)
	) u_timer (
		.clk(clk),
		.reset_n(reset_n),
		.div(rate_div(eff_code)),
		.restart(tx_start || hard_sync),
		.sample(sample),
		.bit_end(bit_end)
	);

	// Idle detection: a run of recessive bits
	reg [3:0] idle_cnt_q;
	wire bus_idle = (idle_cnt_q == `CGN_IDLE_BITS);

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			idle_cnt_q <= 4'h0;
		end else if (state_q == ST_SEND || (sample && !rx_s)) begin
			idle_cnt_q <= 4'h0;
		end else if (sample && !bus_idle) begin
			idle_cnt_q <= idle_cnt_q + 4'h1;
		end
	end

	// Register writes and parameter storage
	reg [31:0] param_mem [0:PARAM_DEPTH-1];
	reg [PIDX_W-1:0] pidx_q;
	reg go_pend_q;
	reg sdo_q;
	reg [3:0] dlc_q;
	reg [63:0] data_q;
	wire wr_ctrl = reg_wr && (reg_addr == `CGN_REG_CTRL);
	wire go_wr = wr_ctrl && reg_wdata[`CGN_CTRL_GO];
	wire [3:0] dlc_w = reg_wdata[`CGN_CTRL_DLC_MSB:`CGN_CTRL_DLC_LSB];

	always @(posedge clk) begin
		if (reg_wr && reg_addr == `CGN_REG_PDAT) begin
			param_mem[pidx_q] <= reg_wdata;
		end
	end

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pidx_q <= {PIDX_W{1'b0}};
			go_pend_q <= 1'b0;
			sdo_q <= 1'b0;
			dlc_q <= 4'h0;
			data_q <= 64'h0000000000000000;
			cfg_node_q <= 7'h00;
			cfg_rate_q <= 4'h0;
			cfg_node_set_q <= 1'b0;
			cfg_rate_set_q <= 1'b0;
		end else begin
			if (tx_start) begin
				go_pend_q <= 1'b0;
			end else if (go_wr) begin
				go_pend_q <= 1'b1;
			end
			if (wr_ctrl) begin
				sdo_q <= reg_wdata[`CGN_CTRL_SDO];
				dlc_q <= (dlc_w > `CGN_MAX_DLC) ? `CGN_MAX_DLC : dlc_w;
			end
			if (reg_wr) begin
				case (reg_addr)
					`CGN_REG_NODE: begin
						cfg_node_q <= reg_wdata[6:0];
						cfg_node_set_q <= 1'b1;
					end
					`CGN_REG_RATE: begin
						cfg_rate_q <= reg_wdata[3:0];
						cfg_rate_set_q <= 1'b1;
					end
					`CGN_REG_DLO: data_q[31:0] <= reg_wdata;
					`CGN_REG_DHI: data_q[63:32] <= reg_wdata;
					`CGN_REG_PIDX: pidx_q <= reg_wdata[PIDX_W-1:0];
					default: begin
					end
				endcase
			end
		end
	end

	// Transmitter with arbitration
	reg [FRAME_W-1:0] shift_q;
	reg [6:0] bits_left_q;
	reg [6:0] bit_idx_q;
	reg lost_q;
	reg err_q;
	reg done_q;
	wire [10:0] ident = {(sdo_q ? `CGN_FC_SDO : `CGN_FC_PDO), node_q};
	wire [6:0] frame_bits = `CGN_HDR_BITS + {dlc_q, 3'h0};
	assign tx_start = (state_q == ST_IDLE) && go_pend_q && comm_enable && bus_idle
		&& bit_end;
	wire mismatch = sample && (rx_s != can_tx);
	wire in_arb = (bit_idx_q < `CGN_ARB_BITS);

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state_q <= ST_IDLE;
			can_tx <= 1'b1;
			shift_q <= {FRAME_W{1'b0}};
			bits_left_q <= 7'h00;
			bit_idx_q <= 7'h00;
			lost_q <= 1'b0;
			err_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			if (go_wr) begin
				lost_q <= 1'b0;
				err_q <= 1'b0;
				done_q <= 1'b0;
			end
			case (state_q)
				ST_IDLE: begin
					can_tx <= 1'b1;
					if (tx_start) begin
						state_q <= ST_SEND;
						shift_q <= {1'b0, ident, 3'h0, dlc_q, data_q};
						can_tx <= 1'b0;
						bits_left_q <= frame_bits;
						bit_idx_q <= 7'h00;
					end
				end
				ST_SEND: begin
					if (mismatch) begin
						state_q <= ST_IDLE;
						can_tx <= 1'b1;
						if (can_tx && in_arb) begin
							lost_q <= 1'b1;
						end else begin
							err_q <= 1'b1;
						end
					end else if (bit_end) begin
						if (bits_left_q == 7'h01) begin
							state_q <= ST_IDLE;
							can_tx <= 1'b1;
							done_q <= 1'b1;
						end else begin
							shift_q <= {shift_q[FRAME_W-2:0], 1'b0};
							can_tx <= shift_q[FRAME_W-2];
							bits_left_q <= bits_left_q - 7'h01;
							bit_idx_q <= bit_idx_q + 7'h01;
						end
					end
				end
				default: begin
					state_q <= ST_IDLE;
					can_tx <= 1'b1;
				end
			endcase
		end
	end

	// Register reads, answered in the following cycle
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			case (reg_addr)
				`CGN_REG_CTRL: reg_rdata <= {20'h00000, dlc_q, 6'h00, sdo_q, go_pend_q};
				`CGN_REG_NODE: reg_rdata <= {25'h0000000, cfg_node_q};
				`CGN_REG_RATE: reg_rdata <= {28'h0000000, cfg_rate_q};
				`CGN_REG_DLO: reg_rdata <= data_q[31:0];
				`CGN_REG_DHI: reg_rdata <= data_q[63:32];
				`CGN_REG_STAT: reg_rdata <= {1'b0, node_q, device_type, eff_code,
					rate_sel_q, 2'h0, auto_done_q, bus_idle, state_q,
					done_q, err_q, lost_q, comm_enable, rate_ok, addr_ok_q,
					power_ready_indicator};
				`CGN_REG_PIDX: reg_rdata <= {{(32-PIDX_W){1'b0}}, pidx_q};
				`CGN_REG_PDAT: reg_rdata <= param_mem[pidx_q];
				default: reg_rdata <= 32'h00000000;
			endcase
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end
endmodule

// File: hdl/cgn_sync3.v
// Three-stage synchroniser for pin inputs.
// Assumes inputs change slowly; the output follows once stages two and three agree.
`timescale 1ns/1ps
module cgn_sync3 #(
	parameter W = 1,
	parameter [W-1:0] RST = {W{1'b0}}
) (
	// Clock and reset
	input wire clk,
	input wire reset_n,
	// Asynchronous input and filtered output
	input wire [W-1:0] async_in,
	output reg [W-1:0] sync_q
);
	reg [W-1:0] s1_q;
	reg [W-1:0] s2_q;
	reg [W-1:0] s3_q;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s1_q <= RST;
			s2_q <= RST;
			s3_q <= RST;
			sync_q <= RST;
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				sync_q <= s3_q;
			end
		end
	end
endmodule

// File: verification/can_gateway_node_setup_tb_top.sv
// Bench for the node-setup block: register tasks, a peer node, scenarios.
// Assumes the bus is a wired-AND of the block and one peer node.
`timescale 1ns/1ps
`include "cgn_consts.vh"
`define CHK(nm, e, g) begin check_count += 1; if ((g) !== (e)) begin error_cnt += 1; \
	$display("BAD %s expected %0h seen %0h", nm, e, g); end end
module can_gateway_node_setup_tb_top;
	reg clk = 1'b0;
	reg reset_n = 1'b1;
	reg [3:0] ones = 4'h0;
	reg [3:0] tens = 4'h0;
	reg [3:0] rate = 4'h0;
	reg [3:0] dev = 4'h0;
	reg [3:0] reg_addr = 4'h0;
	reg [31:0] reg_wdata = 32'h0;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	wire [31:0] reg_rdata;
	wire [3:0] device_type;
	wire can_tx, node_tx, ready, comm;
	wire bus = can_tx & node_tx;
	integer error_cnt = 0;
	integer check_count = 0;
	integer tx_low = 0;
	integer i, k, t0;
	integer kbd [0:9] = '{0, 10, 20, 50, 100, 125, 250, 500, 800, 1000};
	reg [26:0] got, want;
	reg [31:0] rv;
	always #2 clk = ~clk;
	always @(posedge clk) begin
		if (!can_tx)
			tx_low <= tx_low + 1;
	end
	cgn_node_setup #(.CLK_HZ(8000000)) dut (
		.clk(clk), .reset_n(reset_n),
		.address_ones_selector(ones), .address_tens_selector(tens),
		.bit_rate_selector(rate), .attached_device_selector(dev),
		.can_rx(bus), .can_tx(can_tx), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.power_ready_indicator(ready), .device_type(device_type), .comm_enable(comm)
	);
	cgn_bus_node #(.BIT_CYC(8)) peer (.clk(clk), .bus(bus), .node_tx(node_tx));
	task wr(input [3:0] a, input [31:0] d);
		begin
			@(posedge clk);
			reg_addr <= a;
			reg_wdata <= d;
			reg_wr <= 1'b1;
			@(posedge clk);
			reg_wr <= 1'b0;
		end
	endtask
	task rd(input [3:0] a, input [31:0] m, input [31:0] e);
		begin
			@(posedge clk);
			reg_addr <= a;
			reg_rd <= 1'b1;
			@(posedge clk);
			reg_rd <= 1'b0;
			@(negedge clk);
			rv = reg_rdata & m;
			`CHK("register read", e, rv)
		end
	endtask
	task startup(input [3:0] t, input [3:0] o, input [3:0] r, input [3:0] dv);
		begin
			@(posedge clk);
			reset_n <= 1'b0;
			tens <= t;
			ones <= o;
			rate <= r;
			dev <= dv;
			repeat (10) @(posedge clk);
			reset_n <= 1'b1;
			repeat (300) @(posedge clk);
		end
	endtask
	task cfg(input [6:0] node, input [3:0] r);
		begin
			wr(`CGN_REG_NODE, {25'h0, node});
			wr(`CGN_REG_RATE, {28'h0, r});
		end
	endtask
	task go(input sdo, input [3:0] dlc);
		wr(`CGN_REG_CTRL, {20'h0, dlc, 6'h0, sdo, 1'b1});
	endtask
	task expect_comm(input e);
		begin
			repeat (4) @(negedge clk);
			`CHK("comm enable", e, comm)
		end
	endtask
	// Leaves the bench at the first falling edge with the frame started
	task wait_sof;
		begin
			t0 = 0;
			@(negedge clk);
			while (can_tx === 1'b1 && t0 < 20000) begin
				@(negedge clk);
				t0 = t0 + 1;
			end
			`CHK("frame start", 1'b0, can_tx)
		end
	endtask
	task give_verdict;
		begin
			$display("checks %0d errors %0d", check_count, error_cnt);
			if (error_cnt == 0 && check_count > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	initial begin
		repeat (100000) @(posedge clk);
		error_cnt = error_cnt + 1;
		give_verdict;
	end
	initial begin
		// Reset edge at time zero, so every flop but param_mem is defined at the first clock
		reset_n <= 1'b0;
		startup(4'h4, 4'h2, 4'h9, 4'h5);
		`CHK("ready", 1'b1, ready)
		`CHK("device type", 4'h5, device_type)
		rd(`CGN_REG_STAT, 32'h00FFF000, 32'h00599000);
		for (i = 0; i < 3; i = i + 1) begin
			cfg(i == 0 ? 7'h29 : 7'h2A, i == 1 ? 4'h7 : 4'h9);
			expect_comm(i == 2);
		end
		wr(`CGN_REG_PIDX, 32'h3);
		wr(`CGN_REG_PDAT, 32'h12345678);
		wr(`CGN_REG_PIDX, 32'h4);
		wr(`CGN_REG_PDAT, 32'hCAFE0001);
		wr(`CGN_REG_DHI, 32'hA5000000);
		for (k = 0; k < 2; k = k + 1) begin
			want = {1'b0, k ? `CGN_FC_SDO : `CGN_FC_PDO, 7'h2A, 7'h01, 8'hA5};
			go(k[0], 4'h1);
			wait_sof;
			repeat (4) @(negedge clk);
			for (i = 0; i < 27; i = i + 1) begin
				got = {got[25:0], can_tx};
				repeat (8) @(negedge clk);
			end
			`CHK("frame bits", want, got)
			repeat (16) @(negedge clk);
			rd(`CGN_REG_STAT, 32'h70, 32'h40);
		end
		// Peer with the smaller address joins the start bit and must win
		fork
			peer.send(11'h185, 1'b1);
			begin
				go(1'b0, 4'h0);
				wait_sof;
				repeat (59) @(negedge clk);
				k = tx_low;
				repeat (92) @(negedge clk);
				`CHK("silent after loss", k, tx_low)
			end
		join
		rd(`CGN_REG_STAT, 32'h50, 32'h10);
		startup(4'h4, 4'h2, 4'h9, 4'h0);
		wr(`CGN_REG_PIDX, 32'h3);
		rd(`CGN_REG_PDAT, 32'hFFFFFFFF, 32'h12345678);
		rd(4'hF, 32'hFFFFFFFF, 32'h0);
		for (i = 0; i < 3; i = i + 1) begin
			startup(i == 0 ? 4'hA : 4'h9, 4'h9, i == 1 ? 4'hA : 4'h9, 4'h0);
			cfg(7'h63, 4'h9);
			go(1'b0, 4'h0);
			k = tx_low;
			repeat (150) @(negedge clk);
			`CHK("enable", i == 2, comm)
			`CHK("transmitted", i == 2, tx_low != k)
		end
		for (i = 1; i < 10; i = i + 1) begin
			startup(4'h4, 4'h2, i[3:0], 4'h0);
			cfg(7'h2A, i[3:0]);
			go(1'b0, 4'h0);
			wait_sof;
			t0 = 0;
			while (can_tx === 1'b0 && t0 < 3000) begin
				@(negedge clk);
				t0 = t0 + 1;
			end
			`CHK("leading dominant run", 3 * (8000 / kbd[i]), t0)
		end
		startup(4'h4, 4'h2, 4'h0, 4'h0);
		cfg(7'h2A, 4'h9);
		go(1'b0, 4'h0);
		k = tx_low;
		peer.send(11'h555, 1'b0);
		`CHK("quiet before rate known", k, tx_low)
		peer.send(11'h555, 1'b0);
		rd(`CGN_REG_STAT, 32'h000F0200, 32'h00090200);
		wait_sof;
		give_verdict;
	end
endmodule

// File: verification/cgn_bus_node.sv
// Peer node on the bus: sends one data-less frame.
// Assumes a wired-AND bus and BIT_CYC clock cycles per bit.
`timescale 1ns/1ps
module cgn_bus_node #(
	parameter BIT_CYC = 8
) (
	// Clock
	input wire clk,
	// Bus level and own drive
	input wire bus,
	output reg node_tx
);
	initial node_tx = 1'b1;
	// Follow aligns to a start bit already on the bus, else waits for idle
	task send(input [10:0] id, input follow);
		reg [18:0] bits;
		integer i;
		integer n;
		begin
			bits = {1'b0, id, 7'h00};
			n = 0;
			if (follow)
				@(negedge bus);
			while (!follow && n < 11 * BIT_CYC) begin
				@(posedge clk);
				n = bus ? n + 1 : 0;
			end
			for (i = 18; i >= 0; i = i - 1) begin
				node_tx <= bits[i];
				repeat (BIT_CYC / 2) @(posedge clk);
				if (bits[i] && !bus)
					i = -1;
				repeat (BIT_CYC - BIT_CYC / 2) @(posedge clk);
			end
			node_tx <= 1'b1;
		end
	endtask
endmodule

// File: verification/cgn_node_setup_chk.sv
// Checker on the ports of the node-setup block.
// Assumes the selectors change only while reset is held low.
`timescale 1ns/1ps
module cgn_node_setup_chk (
	// Clock and reset
	input wire clk,
	input wire reset_n,
	// Selectors and bus
	input wire [3:0] address_ones_selector,
	input wire [3:0] address_tens_selector,
	input wire [3:0] bit_rate_selector,
	input wire [3:0] attached_device_selector,
	input wire can_rx,
	input wire can_tx,
	// Register port
	input wire [3:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_rdata,
	// Status
	input wire power_ready_indicator,
	input wire [3:0] device_type,
	input wire comm_enable
);
	reg [8:0] cyc_q;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!reset_n);
	// Cycles since reset release, saturating
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			cyc_q <= 9'h000;
		else if (cyc_q != 9'h1FF)
			cyc_q <= cyc_q + 9'h001;
	end
	a_reset_quiet: assert property (disable iff (1'b0) !reset_n |-> can_tx && !comm_enable)
		else $error("bus or enable active in reset");
	a_ready_in_time: assert property (cyc_q == 9'h12C |-> power_ready_indicator)
		else $error("ready missing after startup");
	a_ready_not_early: assert property (cyc_q < 9'h0C8 |-> !power_ready_indicator)
		else $error("ready before startup done");
	a_device_latched: assert property ($past(power_ready_indicator) |-> $stable(device_type))
		else $error("device type changed after startup");
	a_tx_enabled: assert property ($fell(can_tx) |-> $past(comm_enable))
		else $error("frame started without enable");
	a_addr_digits: assert property (comm_enable |->
		address_tens_selector <= 4'h9 && address_ones_selector <= 4'h9)
		else $error("enable with address out of range");
	a_rate_code: assert property (comm_enable |-> bit_rate_selector <= 4'h9)
		else $error("enable with undefined rate code");
	a_enable_ready: assert property (comm_enable |-> power_ready_indicator)
		else $error("enable before ready");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data outside read cycle");
endmodule
bind cgn_node_setup cgn_node_setup_chk u_chk (
	.clk(clk), .reset_n(reset_n),
	.address_ones_selector(address_ones_selector), .address_tens_selector(address_tens_selector),
	.bit_rate_selector(bit_rate_selector), .attached_device_selector(attached_device_selector),
	.can_rx(can_rx), .can_tx(can_tx), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.power_ready_indicator(power_ready_indicator), .device_type(device_type),
	.comm_enable(comm_enable)
);
